// *** merit_regs.sv ***
// Per-channel adaptation merit register slice with tap readback
`timescale 1ns/1ps
`include "merit_consts.svh"
module equalizer_adapt_merit_regs (
   // Clock and reset
   input  wire logic                i_clk,
   input  wire logic                i_sys_rst,
   // Register access from the control bus slave
   input  wire logic [7:0]          i_reg_addr,
   input  wire logic                i_reg_wr,
   input  wire logic                i_reg_rd,
   input  wire logic [7:0]          i_reg_wdata,
   output logic [7:0]               o_reg_rdata,
   output logic                     o_reg_rvalid,
   // Configuration EEPROM load
   input  wire logic                i_ee_wr,
   input  wire logic [7:0]          i_ee_addr,
   input  wire logic [7:0]          i_ee_data,
   // Eye monitor results
   input  wire logic [7:0]          i_horizontal_eye_opening,
   input  wire logic [7:0]          i_vertical_eye_opening,
   input  wire logic                i_eye_sample,
   // Feedback equalizer tap results
   input  wire logic                i_tap_update,
   input  wire logic [4:0]          i_tap_pol,
   input  wire logic [4:0]          i_tap1_mag,
   input  wire logic [15:0]         i_tapn_mag,
   // Rate and boost
   input  wire merit_pkg::rate_sel_t i_rate_sel,
   input  wire logic [7:0]          i_boost_reg,
   input  wire logic [7:0]          i_adapted_boost,
   // Adaptation controls
   output merit_pkg::score_t        o_lineq_merit,
   output merit_pkg::score_t        o_feq_merit,
   output logic                     o_merit_valid,
   output logic [2:0]               o_look_beyond,
   output logic                     o_lineq_adapt_en,
   output logic [7:0]               o_lineq_boost
);
   logic [7:0]  term_a_r;
   logic [7:0]  term_b_r;
   logic [7:0]  term_c_r;
   logic        alt_lineq_r;
   logic        alt_feq_r;
   logic [2:0]  look_beyond_r;
   logic [5:0]  tap1_r;
   logic [4:0]  tapn_r [2:5];
   logic [7:0]  rdata_nxt;
   logic        subrate_slow;
   logic        host_wr;
   logic [7:0]  wr_addr;
   logic [7:0]  wr_data;
   logic [7:0]  last_addr_r;
   logic        last_rd_r;

   merit_if mif ();

   // Host write takes priority; EEPROM load only happens when the host is idle
   always_comb begin
      host_wr = i_reg_wr;
      wr_addr = i_reg_wr ? i_reg_addr : i_ee_addr;
      wr_data = i_reg_wr ? i_reg_wdata : i_ee_data;
   end

   // Merit weighting terms, reachable from host and EEPROM
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         term_a_r <= `RST_TERM_A;
         term_b_r <= `RST_TERM_B;
         term_c_r <= `RST_TERM_C;
      end else if (host_wr || i_ee_wr) begin
         if (wr_addr == `ADDR_TERM_A) term_a_r <= wr_data;
         if (wr_addr == `ADDR_TERM_B) term_b_r <= wr_data;
         if (wr_addr == `ADDR_TERM_C) term_c_r <= wr_data;
      end
   end

   // Alternate merit enables; both bits are EEPROM storable, reserved bits dropped
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         {alt_lineq_r, alt_feq_r} <= `RST_ALT_EN;
      end else if ((host_wr || i_ee_wr) && wr_addr == `ADDR_ALT_EN) begin
         alt_lineq_r <= wr_data[`BIT_ALT_LINEQ];
         alt_feq_r   <= wr_data[`BIT_ALT_FEQ];
      end
   end

   // Look-beyond count is not EEPROM storable, so only the host writes it
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         look_beyond_r <= `RST_LOOK_BEYOND;
      end else if (host_wr && i_reg_addr == `ADDR_LOOK_BEYOND) begin
         look_beyond_r <= i_reg_wdata[`LB_MSB:0];
      end
   end

   // Tap 1 readback follows the adaptation engine only, host writes never land here
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         tap1_r <= 6'h00;
      end else if (i_tap_update) begin
         tap1_r <= {i_tap_pol[0], i_tap1_mag};
      end
   end

   // Taps 2 to 5 share one layout
   for (genvar t = 2; t <= 5; t++) begin : g_tap
      always_ff @(posedge i_clk) begin
         if (i_sys_rst) begin
            tapn_r[t] <= 5'h00;
         end else if (i_tap_update) begin
            tapn_r[t] <= {i_tap_pol[t-1], i_tapn_mag[(t-2)*4 +: 4]};
         end
      end
   end

   // Read mux; reserved bits and unmapped addresses read zero
   always_comb begin
      rdata_nxt = 8'h00;
      case (i_reg_addr)
         `ADDR_TERM_A:      rdata_nxt = term_a_r;
         `ADDR_TERM_B:      rdata_nxt = term_b_r;
         `ADDR_TERM_C:      rdata_nxt = term_c_r;
         `ADDR_ALT_EN:      rdata_nxt = {alt_lineq_r, alt_feq_r, 6'h00};
         `ADDR_LOOK_BEYOND: rdata_nxt = {5'h00, look_beyond_r};
         `ADDR_TAP1:        rdata_nxt = {2'b00, tap1_r};
         `ADDR_TAP2:        rdata_nxt = {3'b000, tapn_r[2]};
         `ADDR_TAP3:        rdata_nxt = {3'b000, tapn_r[3]};
         `ADDR_TAP4:        rdata_nxt = {3'b000, tapn_r[4]};
         `ADDR_TAP5:        rdata_nxt = {3'b000, tapn_r[5]};
         default:           rdata_nxt = 8'h00;
      endcase
   end

   // Read data registered, one cycle after the read strobe
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata  <= 8'h00;
         o_reg_rvalid <= 1'b0;
         last_addr_r  <= 8'h00;
         last_rd_r    <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         last_addr_r  <= i_reg_addr;
         last_rd_r    <= i_reg_rd;
         if (i_reg_rd) o_reg_rdata <= rdata_nxt;
      end
   end

   // Merit calculator operands
   assign mif.horizontal_eye_opening       = i_horizontal_eye_opening;
   assign mif.vertical_eye_opening       = i_vertical_eye_opening;
   assign mif.term_a    = term_a_r;
   assign mif.term_b    = term_b_r;
   assign mif.term_c    = term_c_r;
   assign mif.alt_lineq = alt_lineq_r;
   assign mif.alt_feq   = alt_feq_r;
   assign mif.sample    = i_eye_sample;

   merit_calc u_calc (
      .i_clk     (i_clk),
      .i_sys_rst (i_sys_rst),
      .mif       (mif)
   );

   // Slow subrates bypass adaptation; the fixed boost is then the only source
   assign subrate_slow = (i_rate_sel == merit_pkg::RATE_QUARTER) || (i_rate_sel == merit_pkg::RATE_EIGHTH);

   // Adaptation outputs registered so they change cleanly on rate switches
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_lineq_adapt_en <= 1'b0;
         o_lineq_boost    <= 8'h00;
      end else begin
         o_lineq_adapt_en <= !subrate_slow;
         o_lineq_boost    <= subrate_slow ? i_boost_reg : i_adapted_boost;
      end
   end

   assign o_lineq_merit = mif.lineq_score;
   assign o_feq_merit   = mif.feq_score;
   assign o_merit_valid = mif.score_valid;
   assign o_look_beyond = look_beyond_r;

   property p_reset_terms;
      @(posedge i_clk)
      i_sys_rst |=> (term_a_r == `RST_TERM_A && term_b_r == `RST_TERM_B && term_c_r == `RST_TERM_C
                     && look_beyond_r == `RST_LOOK_BEYOND && !alt_lineq_r && !alt_feq_r);
   endproperty
   a_reset_terms: assert property (p_reset_terms) else $error("reset values wrong");

   property p_term_b_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `ADDR_TERM_B) |=> (term_b_r == $past(i_reg_wdata));
   endproperty
   a_term_b_write: assert property (p_term_b_write) else $error("term B write lost");

   property p_term_c_read;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_rd && i_reg_addr == `ADDR_TERM_C) |=> (o_reg_rvalid && o_reg_rdata == $past(term_c_r));
   endproperty
   a_term_c_read: assert property (p_term_c_read) else $error("term C readback wrong");

   property p_alt_lineq_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `ADDR_ALT_EN) |=> (alt_lineq_r == $past(i_reg_wdata[`BIT_ALT_LINEQ]));
   endproperty
   a_alt_lineq_write: assert property (p_alt_lineq_write) else $error("alternate enable write lost");

   property p_look_beyond_ee;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_ee_wr && !i_reg_wr) |=> $stable(look_beyond_r);
   endproperty
   a_look_beyond_ee: assert property (p_look_beyond_ee) else $error("EEPROM touched look-beyond");

   property p_tap1_read;
      @(posedge i_clk) disable iff (i_sys_rst)
      (last_rd_r && last_addr_r == `ADDR_TAP1) |-> (o_reg_rdata == {2'b00, $past(tap1_r)});
   endproperty
   a_tap1_read: assert property (p_tap1_read) else $error("tap 1 readback wrong");

   property p_tap_write_ignored;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && !i_tap_update && i_reg_addr >= `ADDR_TAP1 && i_reg_addr <= `ADDR_TAP5)
         |=> $stable(tap1_r) && $stable(tapn_r[2]) && $stable(tapn_r[5]);
   endproperty
   a_tap_write_ignored: assert property (p_tap_write_ignored) else $error("tap changed on host write");

   property p_tap5_capture;
      @(posedge i_clk) disable iff (i_sys_rst)
      i_tap_update |=> (tapn_r[5] == {$past(i_tap_pol[4]), $past(i_tapn_mag[15:12])});
   endproperty
   a_tap5_capture: assert property (p_tap5_capture) else $error("tap 5 capture wrong");

   property p_slow_bypass;
      @(posedge i_clk) disable iff (i_sys_rst)
      subrate_slow |=> (!o_lineq_adapt_en && o_lineq_boost == $past(i_boost_reg));
   endproperty
   a_slow_bypass: assert property (p_slow_bypass) else $error("slow subrate not bypassed");

   property p_term_a_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `ADDR_TERM_A) |=> (term_a_r == $past(i_reg_wdata));
   endproperty
   a_term_a_write: assert property (p_term_a_write) else $error("term A write lost");

   property p_term_c_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `ADDR_TERM_C) |=> (term_c_r == $past(i_reg_wdata));
   endproperty
   a_term_c_write: assert property (p_term_c_write) else $error("term C write lost");

   property p_alt_feq_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `ADDR_ALT_EN) |=> (alt_feq_r == $past(i_reg_wdata[`BIT_ALT_FEQ]));
   endproperty
   a_alt_feq_write: assert property (p_alt_feq_write) else $error("feedback enable write lost");

   // EEPROM load lands only when the host is quiet in that cycle
   property p_ee_alt_load;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_ee_wr && !i_reg_wr && i_ee_addr == `ADDR_ALT_EN) |=> (alt_feq_r == $past(i_ee_data[`BIT_ALT_FEQ]));
   endproperty
   a_ee_alt_load: assert property (p_ee_alt_load) else $error("EEPROM enable load lost");

   property p_look_beyond_write;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_wr && i_reg_addr == `ADDR_LOOK_BEYOND) |=> (o_look_beyond == $past(i_reg_wdata[`LB_MSB:0]));
   endproperty
   a_look_beyond_write: assert property (p_look_beyond_write) else $error("look-beyond write lost");

   property p_look_beyond_read;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_reg_rd && i_reg_addr == `ADDR_LOOK_BEYOND) |=> (o_reg_rdata == {5'h00, $past(look_beyond_r)});
   endproperty
   a_look_beyond_read: assert property (p_look_beyond_read) else $error("look-beyond readback wrong");

   property p_tapn_read;
      @(posedge i_clk) disable iff (i_sys_rst)
      (last_rd_r && last_addr_r >= `ADDR_TAP2 && last_addr_r <= `ADDR_TAP5) |-> (o_reg_rdata[7:5] == 3'b000);
   endproperty
   a_tapn_read: assert property (p_tapn_read) else $error("tap reserved bits not zero");

   property p_tap1_capture;
      @(posedge i_clk) disable iff (i_sys_rst)
      i_tap_update |=> (tap1_r == {$past(i_tap_pol[0]), $past(i_tap1_mag)});
   endproperty
   a_tap1_capture: assert property (p_tap1_capture) else $error("tap 1 capture wrong");

   // Tap readback moves only on an adaptation update, whatever the host does
   property p_tap_hold;
      @(posedge i_clk) disable iff (i_sys_rst)
      !i_tap_update |=> $stable(tap1_r) && $stable(tapn_r[3]) && $stable(tapn_r[4]);
   endproperty
   a_tap_hold: assert property (p_tap_hold) else $error("tap moved without update");

   property p_full_rate_adapt;
      @(posedge i_clk) disable iff (i_sys_rst)
      !subrate_slow |=> (o_lineq_adapt_en && o_lineq_boost == $past(i_adapted_boost));
   endproperty
   a_full_rate_adapt: assert property (p_full_rate_adapt) else $error("fast rate not adapting");

   // A closed horizontal eye leaves nothing for the alternate minimum
   property p_alt_lineq_closed;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_eye_sample && alt_lineq_r && i_horizontal_eye_opening <= term_b_r) |=> (o_lineq_merit == 10'h000);
   endproperty
   a_alt_lineq_closed: assert property (p_alt_lineq_closed) else $error("alternate score not zero");

   // A weight of 128 or more leaves the vertical term empty, so the minimum is zero
   property p_std_no_vertical;
      @(posedge i_clk) disable iff (i_sys_rst)
      (i_eye_sample && !alt_lineq_r && term_a_r >= `MERIT_WEIGHT_FULL) |=> (o_lineq_merit == 10'h000);
   endproperty
   a_std_no_vertical: assert property (p_std_no_vertical) else $error("standard score not zero");
endmodule

// *** merit_consts.svh ***
// Offsets, field positions, reset values and arithmetic constants of the merit register slice
// Function
// - The merit score is min[(horizontal_eye_opening - B)*A/127, (vertical_eye_opening - C)*(128 - A)/127], with C at merit_vertical_offset resetting to zero.
// - Bit 7 of alternate_merit_enables, reset 0, selects the alternate merit function for linear_equalizer adaptation.
// - Bit 6 of alternate_merit_enables, reset 0 and EEPROM loadable, selects the alternate merit function for feedback_equalizer adaptation.
// - Bits 2:0 of lineq_look_beyond hold the linear_equalizer look-beyond count, reset to binary 011.
// - Register tap1_readback reads back tap 1 polarity in bit 5 and 5-bit magnitude in bits 4:0.
// - Registers tap2_readback to tap5_readback read back taps 2 to 5 with polarity in bit 4 and 4-bit magnitude in bits 3:0.
// - At quarter or eighth rate_oscillator subrate linear_equalizer adaptation is skipped and the 0x3A boost is applied.
// - Term A lives at 0x6B, 8-bit read-write, reset 0x40.
// - Term B lives at 0x6C, 8-bit read-write, reset zero.
`ifndef MERIT_CONSTS_SVH
`define MERIT_CONSTS_SVH

`define ADDR_TERM_A       8'h6B
`define ADDR_TERM_B       8'h6C
`define ADDR_TERM_C       8'h6D
`define ADDR_ALT_EN       8'h6E
`define ADDR_RSVD_6F      8'h6F
`define ADDR_LOOK_BEYOND  8'h70
`define ADDR_TAP1         8'h71
`define ADDR_TAP2         8'h72
`define ADDR_TAP3         8'h73
`define ADDR_TAP4         8'h74
`define ADDR_TAP5         8'h75

`define RST_TERM_A        8'h40
`define RST_TERM_B        8'h00
`define RST_TERM_C        8'h00
`define RST_ALT_EN        2'h0
`define RST_LOOK_BEYOND   3'h3

`define BIT_ALT_LINEQ     7
`define BIT_ALT_FEQ       6
`define LB_MSB            2
`define TAP1_POL_BIT      5
`define TAPN_POL_BIT      4

`define MERIT_DIVISOR     10'h07F
`define MERIT_WEIGHT_FULL 8'h80

`endif

// *** merit_pkg.sv ***
// Types shared by the merit register slice
package merit_pkg;
   typedef enum logic [1:0] {
      RATE_FULL,
      RATE_HALF,
      RATE_QUARTER,
      RATE_EIGHTH
   } rate_sel_t;

   typedef logic [9:0] score_t;
endpackage

// *** merit_if.sv ***
// Carrier between the register slice and the merit score calculator
`timescale 1ns/1ps
interface merit_if;
   logic [7:0]            horizontal_eye_opening;
   logic [7:0]            vertical_eye_opening;
   logic [7:0]            term_a;
   logic [7:0]            term_b;
   logic [7:0]            term_c;
   logic                  alt_lineq;
   logic                  alt_feq;
   logic                  sample;
   merit_pkg::score_t     lineq_score;
   merit_pkg::score_t     feq_score;
   logic                  score_valid;

   modport ctrl (output horizontal_eye_opening, vertical_eye_opening, term_a, term_b, term_c, alt_lineq, alt_feq, sample,
                 input lineq_score, feq_score, score_valid);
   modport calc (input horizontal_eye_opening, vertical_eye_opening, term_a, term_b, term_c, alt_lineq, alt_feq, sample,
                 output lineq_score, feq_score, score_valid);
endinterface

// *** merit_calc.sv ***
// Adaptation merit score calculator, one registered stage
`timescale 1ns/1ps
`include "merit_consts.svh"
module merit_calc (
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   // Operands and scores
   merit_if.calc     mif
);
   logic [7:0]            h_off;
   logic [7:0]            v_off;
   logic [7:0]            v_wt;
   logic [15:0]           h_prod;
   logic [15:0]           v_prod;
   merit_pkg::score_t     h_term;
   merit_pkg::score_t     v_term;
   merit_pkg::score_t     std_score;
   merit_pkg::score_t     alt_score;

   // Eye offsets clamp at zero so a small eye never wraps into a large score
   always_comb begin
      h_off = (mif.horizontal_eye_opening > mif.term_b) ? 8'(mif.horizontal_eye_opening - mif.term_b) : 8'h00;
      v_off = (mif.vertical_eye_opening > mif.term_c) ? 8'(mif.vertical_eye_opening - mif.term_c) : 8'h00;
      v_wt  = (mif.term_a < `MERIT_WEIGHT_FULL) ? 8'(`MERIT_WEIGHT_FULL - mif.term_a) : 8'h00; // A above 128 leaves no vertical weight
      h_prod = h_off * mif.term_a;
      v_prod = v_off * v_wt;
      h_term = 10'(h_prod / 16'(`MERIT_DIVISOR));
      v_term = 10'(v_prod / 16'(`MERIT_DIVISOR));
      std_score = (h_term < v_term) ? h_term : v_term;
      alt_score = (h_off < v_off) ? {2'b00, h_off} : {2'b00, v_off}; // Unweighted minimum
   end

   // Score register, one cycle after the sample strobe
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         mif.lineq_score <= 10'h000;
         mif.feq_score   <= 10'h000;
         mif.score_valid <= 1'b0;
      end else begin
         mif.score_valid <= mif.sample;
         if (mif.sample) begin
            mif.lineq_score <= mif.alt_lineq ? alt_score : std_score;
            mif.feq_score   <= mif.alt_feq ? alt_score : std_score;
         end
      end
   end

   property p_score_latency;
      @(posedge i_clk) disable iff (i_sys_rst)
      mif.sample |=> mif.score_valid;
   endproperty
   a_score_latency: assert property (p_score_latency) else $error("score valid missing");

   property p_std_is_min;
      @(posedge i_clk) disable iff (i_sys_rst)
      (mif.sample && !mif.alt_lineq) |=> (mif.lineq_score == $past(std_score))
         && (mif.lineq_score <= $past(h_term)) && (mif.lineq_score <= $past(v_term));
   endproperty
   a_std_is_min: assert property (p_std_is_min) else $error("standard score not minimum");

   property p_alt_feq;
      @(posedge i_clk) disable iff (i_sys_rst)
      (mif.sample && mif.alt_feq) |=> (mif.feq_score == $past(alt_score));
   endproperty
   a_alt_feq: assert property (p_alt_feq) else $error("alternate feq score wrong");
endmodule

// *** ee_loader_model.sv ***
// Configuration EEPROM loader model that streams merit terms into the slice
`timescale 1ns/1ps
module ee_loader_model (
   // Clock and control
   input  wire logic       i_clk,
   input  wire logic       i_start,
   // Load strobe toward the slice
   output logic            o_ee_wr,
   output logic [7:0]      o_ee_addr,
   output logic [7:0]      o_ee_data,
   output logic            o_done
);
   logic [7:0] img_addr [4] = '{8'h6B, 8'h6C, 8'h6D, 8'h6E};
   logic [7:0] img_data [4] = '{8'h21, 8'h05, 8'h07, 8'h40};
   int         idx          = 4;

   initial begin
      o_ee_wr   = 1'b0;
      o_ee_addr = 8'h00;
      o_ee_data = 8'h00;
   end

   // One entry per cycle; released lines toggle so stale bytes never look valid
   always @(posedge i_clk) begin
      if (i_start && idx == 4) begin
         idx <= 0;
      end
      if (idx < 4) begin
         o_ee_wr   <= 1'b1;
         o_ee_addr <= img_addr[idx];
         o_ee_data <= img_data[idx];
         idx       <= idx + 1;
      end else begin
         o_ee_wr   <= 1'b0;
         o_ee_addr <= ~o_ee_addr;
         o_ee_data <= ~o_ee_data;
      end
   end

   assign o_done = (idx == 4) && !o_ee_wr;
endmodule

// *** test_equalizer_adapt_merit_regs.sv ***
// Self-checking testbench for the adaptation merit register slice
`timescale 1ns/1ps
module test_equalizer_adapt_merit_regs;
   logic                 clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, sample = 1'b0, tap_upd = 1'b0;
   logic [7:0]           addr = 8'h00, wdata = 8'h00, horizontal_eye_opening = 8'h00, vertical_eye_opening = 8'h00, breg = 8'h00, abst = 8'h00;
   logic [4:0]           pol = 5'h00, m1 = 5'h00;
   logic [15:0]          mn = 16'h0000;
   merit_pkg::rate_sel_t rate = merit_pkg::RATE_FULL;
   logic                 ee_start = 1'b0, ee_wr, ee_done, rvalid, mvalid, adapt_en;
   logic [7:0]           ee_addr, ee_data, rdata, boost, ta, tb, tc, en6e;
   logic [2:0]           look;
   merit_pkg::score_t    s_lin, s_feq;
   int                   n_mismatch = 0, tests_run = 0, cycles = 0, k, r;

   always #2.5 clk = ~clk;

   equalizer_adapt_merit_regs equalizer_adapt_merit_regs_i (
      .i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_ee_wr(ee_wr),
      .i_ee_addr(ee_addr), .i_ee_data(ee_data), .i_horizontal_eye_opening(horizontal_eye_opening),
      .i_vertical_eye_opening(vertical_eye_opening), .i_eye_sample(sample), .i_tap_update(tap_upd), .i_tap_pol(pol),
      .i_tap1_mag(m1), .i_tapn_mag(mn), .i_rate_sel(rate), .i_boost_reg(breg), .i_adapted_boost(abst),
      .o_lineq_merit(s_lin), .o_feq_merit(s_feq), .o_merit_valid(mvalid), .o_look_beyond(look),
      .o_lineq_adapt_en(adapt_en), .o_lineq_boost(boost));

   ee_loader_model ee_loader_model_i (
      .i_clk(clk), .i_start(ee_start), .o_ee_wr(ee_wr), .o_ee_addr(ee_addr), .o_ee_data(ee_data),
      .o_done(ee_done));

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Answer lands one edge after the strobe and is sampled once settled
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      chk("read valid", 10'h001, {9'h000, rvalid});
      chk($sformatf("register %h", a), {2'b00, e}, {2'b00, rdata});
   endtask

   // Negative offsets clamp to zero and weights above 128 leave no vertical share
   function automatic logic [9:0] exp_score(input logic [7:0] h, v, a, b, c, input logic alt);
      int dh, dv, w, s1, s2;
      dh = (h > b) ? h - b : 0;
      dv = (v > c) ? v - c : 0;
      w  = (a > 128) ? 0 : 128 - a;
      s1 = alt ? dh : dh * a / 127;
      s2 = alt ? dv : dv * w / 127;
      return 10'((s1 < s2) ? s1 : s2);
   endfunction

   task automatic merit(input logic [7:0] h, input logic [7:0] v);
      @(posedge clk);
      horizontal_eye_opening    <= h;
      vertical_eye_opening    <= v;
      sample <= 1'b1;
      @(posedge clk);
      sample <= 1'b0;
      #1;
      chk("merit valid", 10'h001, {9'h000, mvalid});
      chk("linear score", exp_score(h, v, ta, tb, tc, en6e[7]), s_lin);
      chk("feedback score", exp_score(h, v, ta, tb, tc, en6e[6]), s_feq);
   endtask

   // Hang guard, far above the few hundred cycles the sequence needs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("[FAIL] run length expected below 20000 seen 20000");
         end_of_test();
      end
   end

   initial begin
      void'($urandom(79));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      #1;
      chk("look beyond", 10'h003, {7'h00, look});
      rd_chk(8'h6B, 8'h40);
      rd_chk(8'h6C, 8'h00);
      rd_chk(8'h6D, 8'h00);
      rd_chk(8'h6E, 8'h00);
      rd_chk(8'h6F, 8'h00);
      rd_chk(8'h70, 8'h03);
      for (k = 0; k < 5; k++) rd_chk(8'h71 + 8'(k), 8'h00);
      rd_chk(8'h10, 8'h00);
      $display("test reset_values done");
      reg_wr(8'h70, 8'hFF);
      rd_chk(8'h70, 8'h07);
      chk("look beyond", 10'h007, {7'h00, look});
      reg_wr(8'h6E, 8'hFF);
      rd_chk(8'h6E, 8'hC0);
      reg_wr(8'h6F, 8'hA5);
      rd_chk(8'h6F, 8'h00);
      $display("test field_writes done");
      for (r = 0; r < 3; r++) begin
         @(posedge clk);
         pol     <= (r == 0) ? 5'h1F : 5'($urandom);
         m1      <= (r == 0) ? 5'h1F : 5'($urandom);
         mn      <= (r == 0) ? 16'hFFFF : 16'($urandom);
         tap_upd <= 1'b1;
         @(posedge clk);
         tap_upd <= 1'b0;
         reg_wr(8'h71, 8'h00);
         reg_wr(8'h73, 8'h00);
         rd_chk(8'h71, {2'b00, pol[0], m1});
         for (k = 0; k < 4; k++) rd_chk(8'h72 + 8'(k), {3'b000, pol[k + 1], mn[4 * k +: 4]});
      end
      $display("test tap_readback done");
      @(posedge clk);
      ee_start <= 1'b1;
      @(posedge clk);
      ee_start <= 1'b0;
      #1;
      for (k = 0; k < 20 && ee_done !== 1'b1; k++) @(posedge clk);
      chk("load done", 10'h001, {9'h000, ee_done});
      rd_chk(8'h6B, 8'h21);
      rd_chk(8'h6C, 8'h05);
      rd_chk(8'h6D, 8'h07);
      rd_chk(8'h6E, 8'h40);
      $display("test eeprom_load done");
      for (r = 0; r < 24; r++) begin
         ta   = (r == 0) ? 8'h80 : (r == 1) ? 8'hFF : 8'($urandom);
         tb   = (r < 2) ? 8'h00 : 8'($urandom_range(0, 90));
         tc   = (r < 2) ? 8'h00 : 8'($urandom_range(0, 90));
         en6e = {2'(r % 4), 6'h00};
         reg_wr(8'h6B, ta);
         reg_wr(8'h6C, tb);
         reg_wr(8'h6D, tc);
         reg_wr(8'h6E, en6e);
         merit((r < 2) ? 8'hFF : 8'($urandom), (r < 2) ? 8'hFF : 8'($urandom));
      end
      $display("test merit_scores done");
      // Mid-run reset must bring the written terms back to their defaults
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd_chk(8'h6B, 8'h40);
      rd_chk(8'h6E, 8'h00);
      rd_chk(8'h70, 8'h03);
      rd_chk(8'h71, 8'h00);
      $display("test mid_reset done");
      for (k = 0; k < 4; k++) begin
         @(posedge clk);
         rate <= merit_pkg::rate_sel_t'(k);
         breg <= 8'($urandom);
         abst <= 8'($urandom);
         @(posedge clk);
         #1;
         chk("adapt enable", (k < 2) ? 10'h001 : 10'h000, {9'h000, adapt_en});
         chk("boost", {2'b00, (k < 2) ? abst : breg}, {2'b00, boost});
      end
      $display("test rate_bypass done");
      end_of_test();
   end
endmodule
